// ### pin_function_select_bank.sv
// Twelve pin function select registers behind an APB slave, with per-pin steering outputs.
// Assumes rst is the power-on reset only and that the debug strap is stable while it is held.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module pin_function_select_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic debugModeStrapN,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [pin_function_select_pkg::NUM_PINS-1:0] altFunctionSelect,
  output logic [pin_function_select_pkg::NUM_PINS-1:0] portOutputEnable,
  output logic [pin_function_select_pkg::NUM_PINS-1:0] pullUpEnable
);
  import pin_function_select_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][15:0] fieldReg;
    logic [31:0] readData;
    logic ready;
    logic slaveError;
    logic [NUM_PINS-1:0] altSel;
    logic [NUM_PINS-1:0] drive;
    logic [NUM_PINS-1:0] pull;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [NUM_PINS-1:0] decAlt;
  logic [NUM_PINS-1:0] decDrive;
  logic [NUM_PINS-1:0] decPull;
  logic windowHit;
  logic [3:0] regIdx;
  logic regHit;
  logic accessPhase;

  // Both bases alias the same storage, so cached and uncached views never diverge.
  assign windowHit = (paddr[31:WINDOW_LSB] == BASE_ADDR[31:WINDOW_LSB]) ||
                     (paddr[31:WINDOW_LSB] == ALT_BASE_ADDR[31:WINDOW_LSB]); // [RL12]
  assign regIdx = paddr[WINDOW_LSB-1:2];
  assign regHit = windowHit && (regIdx < 4'(NUM_REGS)) && (paddr[1:0] == 2'h0); // [RL12]
  assign accessPhase = psel && penable;

  // Decoding the stored fields costs one clock of lag but keeps every pin output on a flop.
  for (genvar p = 0; p < NUM_REGS; p++) begin : gPort
    pin_mode_decode #(
      .PINS(PINS_PER_PORT),
      .RESERVED_OUT((p == IDX_PORT_D) ? PORT_D_RESERVED_OUT : NO_RESERVED_OUT)
    ) uDecode (
      .modeField(s_q.fieldReg[p]),
      .altSelect(decAlt[p*PINS_PER_PORT +: PINS_PER_PORT]),
      .driveEnable(decDrive[p*PINS_PER_PORT +: PINS_PER_PORT]),
      .pullUpEnable(decPull[p*PINS_PER_PORT +: PINS_PER_PORT])
    ); // [RL14]
  end

  always_comb begin
    s_d = s_q;
    s_d.altSel = decAlt; // [RL14]
    s_d.drive = decDrive;
    s_d.pull = decPull;
    // One wait state: the answer is prepared in the first access cycle.
    s_d.ready = accessPhase && !s_q.ready;
    if (accessPhase && !s_q.ready) begin
      s_d.slaveError = !regHit;
      if (!pwrite && regHit) begin
        s_d.readData = {16'h0000, s_q.fieldReg[regIdx]}; // [RL14]
      end else begin
        s_d.readData = 32'h00000000;
      end
    end
    if (accessPhase && s_q.ready && pwrite && regHit) begin
      if (pstrb[0]) begin
        s_d.fieldReg[regIdx][7:0] = pwdata[7:0]; // [RL1]
      end
      if (pstrb[1]) begin
        s_d.fieldReg[regIdx][15:8] = pwdata[15:8]; // [RL1]
      end
    end
    // No manual reset or low-power input exists here, so nothing else can touch the fields.
    if (rst) begin
      if (!debugModeStrapN) begin
        s_d.fieldReg = RESET_DEBUG; // [RL5] [RL8] [RL9] [RL10]
      end else begin
        s_d.fieldReg = RESET_NORMAL; // [RL3] [RL6] [RL7] [RL11]
      end
      s_d.readData = 32'h00000000;
      s_d.ready = 1'b0;
      s_d.slaveError = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  assign prdata = s_q.readData;
  assign pready = s_q.ready;
  assign pslverr = s_q.slaveError;
  assign altFunctionSelect = s_q.altSel;
  assign portOutputEnable = s_q.drive;
  assign pullUpEnable = s_q.pull;

  sequence accessWait;
    psel && penable && !pready;
  endsequence

  sequence accessDone;
    psel && penable && pready;
  endsequence

  sequence writeDoneHit;
    accessDone ##0 (pwrite && regHit && pstrb[1:0] == 2'h3);
  endsequence

  property readReturnsStored;
    logic [15:0] held;
    @(posedge clock) disable iff (rst)
      (accessWait ##0 (!pwrite && regHit), held = s_q.fieldReg[regIdx])
        |=> pready && prdata == {16'h0000, held};
  endproperty

  AST_WRITE_STORES: assert property (@(posedge clock) disable iff (rst)
    writeDoneHit |=> s_q.fieldReg[$past(regIdx)] == $past(pwdata[15:0])) // [RL1]
    else $error("Full write did not land in the addressed register.");

  AST_READBACK: assert property (readReturnsStored) // [RL14]
    else $error("Read data differs from the stored register value.");

  AST_ONE_WAIT: assert property (@(posedge clock) disable iff (rst)
    (psel && !penable) ##1 (psel && penable) |=> pready ##1 !pready) // [RL12]
    else $error("Access did not complete after exactly one wait state.");

  AST_UNMAPPED_ERROR: assert property (@(posedge clock) disable iff (rst)
    accessWait ##0 !regHit |=> pready && pslverr && prdata == 32'h00000000) // [RL12]
    else $error("Unmapped address did not answer with an error.");

  AST_ALT_ALIAS: assert property (@(posedge clock) disable iff (rst)
    accessWait ##0 (paddr[31:WINDOW_LSB] == ALT_BASE_ADDR[31:WINDOW_LSB] && regIdx == IDX_PORT_A
      && paddr[1:0] == 2'h0) |=> pready && !pslverr) // [RL12]
    else $error("Alternate base address was not decoded.");

  AST_AB_RESET: assert property (@(posedge clock)
    rst |=> s_q.fieldReg[IDX_PORT_A] == 16'h0000 && s_q.fieldReg[IDX_PORT_B] == 16'h0000) // [RL6]
    else $error("Ports A and B did not clear on power-on reset.");

  AST_C_RESET: assert property (@(posedge clock)
    rst |=> s_q.fieldReg[IDX_PORT_C] == 16'haaaa) // [RL3]
    else $error("Port C did not reset to pulled-up inputs.");

  AST_D_RESET: assert property (@(posedge clock)
    rst |=> s_q.fieldReg[IDX_PORT_D][5:4] == MODE_ALT
      && s_q.fieldReg[IDX_PORT_D][13:12] == MODE_INPUT_PULLUP
      && s_q.fieldReg[IDX_PORT_D][9:8] == MODE_INPUT_PULLUP
      && s_q.fieldReg[IDX_PORT_D] == 16'haa8a) // [RL7] [RL4]
    else $error("Port D reset value is wrong.");

  AST_STRAP_NORMAL: assert property (@(posedge clock)
    rst && debugModeStrapN |=> s_q.fieldReg[IDX_PORT_E] == 16'haaaa
      && s_q.fieldReg[IDX_PORT_F] == 16'haaaa && s_q.fieldReg[IDX_PORT_G] == 16'haaaa
      && s_q.fieldReg[IDX_PORT_H] == 16'haaaa) // [RL8] [RL9] [RL10]
    else $error("Normal-mode reset of ports E to H is wrong.");

  AST_STRAP_DEBUG: assert property (@(posedge clock)
    rst && !debugModeStrapN |=> s_q.fieldReg[IDX_PORT_E] == 16'h2aa8
      && s_q.fieldReg[IDX_PORT_F] == 16'h00aa && s_q.fieldReg[IDX_PORT_G] == 16'ha200
      && s_q.fieldReg[IDX_PORT_H] == 16'h8aaa) // [RL8] [RL9] [RL10]
    else $error("Debug-mode reset of ports E to H is wrong.");

  AST_JKL_SERIAL_RESET: assert property (@(posedge clock)
    rst |=> s_q.fieldReg[IDX_PORT_J] == 16'h0000 && s_q.fieldReg[IDX_PORT_K] == 16'h0000
      && s_q.fieldReg[IDX_PORT_L] == 16'h0000 && s_q.fieldReg[IDX_SERIAL] == 16'ha888) // [RL11]
    else $error("Ports J, K, L or the serial select did not reset correctly.");

  AST_HOLD_WITHOUT_WRITE: assert property (@(posedge clock) disable iff (rst)
    !(psel && penable && pready && pwrite && regHit) |=> $stable(s_q.fieldReg)) // [RL5]
    else $error("Register contents changed with no write and no power-on reset.");

  AST_D_RESERVED_NO_DRIVE: assert property (@(posedge clock) disable iff (rst)
    s_q.fieldReg[IDX_PORT_D][9:8] == MODE_OUTPUT |=> !portOutputEnable[IDX_PORT_D*8+4]) // [RL4]
    else $error("Port D pin 4 drove on its reserved code.");

  AST_ALT_DECODE: assert property (@(posedge clock) disable iff (rst)
    s_q.fieldReg[IDX_PORT_A][1:0] == MODE_ALT ##1 $stable(s_q.fieldReg[IDX_PORT_A][1:0])
      |-> altFunctionSelect[0] && !portOutputEnable[0] && !pullUpEnable[0]) // [RL2]
    else $error("Port A pin 0 peripheral code decoded wrongly.");

  AST_OUTPUT_DECODE: assert property (@(posedge clock) disable iff (rst)
    s_q.fieldReg[IDX_PORT_B][15:14] == MODE_OUTPUT |=> portOutputEnable[15]
      && !altFunctionSelect[15]) // [RL2] [RL14]
    else $error("Port B pin 7 output code decoded wrongly.");

  AST_PULL_DECODE: assert property (@(posedge clock) disable iff (rst)
    s_q.fieldReg[IDX_PORT_C][3:2] == MODE_INPUT_PULLUP |=> pullUpEnable[IDX_PORT_C*8+1]
      && !portOutputEnable[IDX_PORT_C*8+1]) // [RL3]
    else $error("Port C pin 1 pull-up code decoded wrongly.");

endmodule // pin_function_select_bank

// ### pin_function_select_pkg.sv
// Constants for the pin function select bank: register map, reset values and field layout.
// Assumes an APB master with 32-bit data that reaches the bank at one of two base addresses.
// What this block does
// RL1 - Each select register is sixteen bits wide and holds eight two-bit mode fields, pin n at bits 2n+1:2n.
// RL2 - For ports A and B and most port D pins, 00 picks the peripheral, 01 drives out, 10 inputs with pull-up, 11 inputs bare.
// RL3 - Port C uses the same four codes and every port C field comes out of power-on reset as 10.
// RL4 - On port D pins 4 and 6 the code 01 is reserved and never turns the output driver on; both fields reset to 10.
// RL5 - Only power-on reset loads the registers; manual reset, standby and sleep leave them alone.
// RL6 - Ports A and B come out of power-on reset as all zeros, so every pin starts on its peripheral.
// RL7 - Port D comes out of power-on reset with pin 2 on its peripheral and every other pin a pulled-up input.
// RL8 - The reset value of ports E to H follows the debug strap: low during power-on reset is debug, high is normal.
// RL9 - Ports E, F and G reset to their normal value or their debug value as the strap chose.
// RL10 - Port H resets to its normal value or its debug value as the strap chose.
// RL11 - Ports J, K and L clear to zero and the serial port select register takes its own default at power-on reset.
// RL12 - The twelve registers sit in consecutive slots from the base address and answer at the alternate base too.
// RL13 - Software must reach the bank over an uncached path, since it lives in physical area one.
// RL14 - Each mode field steers its pin's multiplexer and pull-up, and a read returns the last written or reset value.
package pin_function_select_pkg;

  localparam int unsigned NUM_REGS = 12;
  localparam int unsigned PINS_PER_PORT = 8;
  localparam int unsigned NUM_PINS = NUM_REGS * PINS_PER_PORT;
  localparam int unsigned REG_WIDTH = 16;

  // The native map steps by two bytes; on APB each register takes one word at base plus four times its index.
  localparam logic [31:0] BASE_ADDR = 32'h04000100;
  localparam logic [31:0] ALT_BASE_ADDR = 32'ha4000100;
  localparam logic [31:0] PRINTED_STRIDE = 32'h00000002;
  localparam logic [NUM_REGS-1:0][31:0] PRINTED_ADDR = {
    32'h04000116, 32'h04000114, 32'h04000112, 32'h04000110,
    32'h0400010e, 32'h0400010c, 32'h0400010a, 32'h04000108,
    32'h04000106, 32'h04000104, 32'h04000102, 32'h04000100};

  // Register indexes, in map order.
  localparam logic [3:0] IDX_PORT_A = 4'h0;
  localparam logic [3:0] IDX_PORT_B = 4'h1;
  localparam logic [3:0] IDX_PORT_C = 4'h2;
  localparam logic [3:0] IDX_PORT_D = 4'h3;
  localparam logic [3:0] IDX_PORT_E = 4'h4;
  localparam logic [3:0] IDX_PORT_F = 4'h5;
  localparam logic [3:0] IDX_PORT_G = 4'h6;
  localparam logic [3:0] IDX_PORT_H = 4'h7;
  localparam logic [3:0] IDX_PORT_J = 4'h8;
  localparam logic [3:0] IDX_PORT_K = 4'h9;
  localparam logic [3:0] IDX_PORT_L = 4'ha;
  localparam logic [3:0] IDX_SERIAL = 4'hb;

  // Window decode: paddr bits from this one upward must match a base.
  localparam int unsigned WINDOW_LSB = 6;

  // Mode field codes.
  localparam logic [1:0] MODE_ALT = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h1;
  localparam logic [1:0] MODE_INPUT_PULLUP = 2'h2;
  localparam logic [1:0] MODE_INPUT_BARE = 2'h3;

  // Pins whose output code is reserved and must not drive.
  localparam logic [7:0] PORT_D_RESERVED_OUT = 8'h50;
  localparam logic [7:0] NO_RESERVED_OUT = 8'h00;

  // Power-on values with the strap high (normal) and low (debug).
  localparam logic [NUM_REGS-1:0][15:0] RESET_NORMAL = {
    16'ha888, 16'h0000, 16'h0000, 16'h0000,
    16'haaaa, 16'haaaa, 16'haaaa, 16'haaaa,
    16'haa8a, 16'haaaa, 16'h0000, 16'h0000};
  localparam logic [NUM_REGS-1:0][15:0] RESET_DEBUG = {
    16'ha888, 16'h0000, 16'h0000, 16'h0000,
    16'h8aaa, 16'ha200, 16'h00aa, 16'h2aa8,
    16'haa8a, 16'haaaa, 16'h0000, 16'h0000};

endpackage

// ### pin_mode_decode.sv
// Decoder from one port's packed mode fields to per-pin steering signals.
// Assumes the fields arrive from stored register bits; the decoder itself holds no state.
`timescale 1ns/100ps
module pin_mode_decode #(
  parameter int unsigned PINS = 8,
  parameter logic [7:0] RESERVED_OUT = 8'h00
) (
  input wire logic [2*PINS-1:0] modeField,
  output logic [PINS-1:0] altSelect,
  output logic [PINS-1:0] driveEnable,
  output logic [PINS-1:0] pullUpEnable
);
  import pin_function_select_pkg::*;

  if (PINS < 1 || PINS > 8) begin : gBadPins
    $error("pin_mode_decode supports one to eight pins per port");
  end

  for (genvar n = 0; n < PINS; n++) begin : gPin
    logic [1:0] code;
    assign code = modeField[2*n+1:2*n]; // [RL1]
    assign altSelect[n] = (code == MODE_ALT); // [RL2] [RL14]
    // A reserved output code leaves the pin floating as an input rather than guess a drive.
    assign driveEnable[n] = (code == MODE_OUTPUT) && !RESERVED_OUT[n]; // [RL4]
    assign pullUpEnable[n] = (code == MODE_INPUT_PULLUP); // [RL2] [RL3]
  end

endmodule // pin_mode_decode

// ### pin_function_select_bank_tb.sv
// Self-checking testbench for the pin function select bank: reset values, APB access, pin steering.
// Assumes the bank answers one APB access at a time and that rst is the only power-on reset.
`timescale 1ns/100ps
module pin_function_select_bank_tb;
  import pin_function_select_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic debugModeStrapN = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [95:0] altFunctionSelect;
  logic [95:0] portOutputEnable;
  logic [95:0] pullUpEnable;
  logic [15:0] shadow [12];
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int compares = 0;

  always #50 clock = ~clock;

  pin_function_select_bank u_dut (
    .clock(clock), .rst(rst), .debugModeStrapN(debugModeStrapN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .altFunctionSelect(altFunctionSelect),
    .portOutputEnable(portOutputEnable), .pullUpEnable(pullUpEnable));

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Entered just after a rising edge; leaves one idle cycle so psel is never assigned twice.
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                     input logic [3:0] strb);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [15:0] expReset(input int idx, input logic dbg);
    case (idx)
      2: return 16'haaaa;
      3: return 16'haa8a;
      4: return dbg ? 16'h2aa8 : 16'haaaa;
      5: return dbg ? 16'h00aa : 16'haaaa;
      6: return dbg ? 16'ha200 : 16'haaaa;
      7: return dbg ? 16'h8aaa : 16'haaaa;
      11: return 16'ha888;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [95:0] expPins(input int kind);
    logic [95:0] r;
    logic [1:0] f;
    r = '0;
    for (int i = 0; i < 96; i++) begin
      f = shadow[i/8][2*(i%8) +: 2];
      r[i] = (f == kind[1:0]) && !(kind == 1 && (i == 28 || i == 30));
    end
    return r;
  endfunction

  task automatic readAll(input logic [31:0] base);
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, base + 32'(4 * i), 32'h0, 4'h0);
      check({95'h0, err}, 96'h0);
      check(rd, {16'h0, shadow[i]});
    end
  endtask

  task automatic checkPins();
    repeat (2) @(posedge clock);
    check(altFunctionSelect, expPins(0));
    check(portOutputEnable, expPins(1));
    check(pullUpEnable, expPins(2));
  endtask

  initial begin
    logic [31:0] v;
    logic [3:0] s;
    int idx;
    logic [31:0] bad [4];
    bad = '{BASE_ADDR + 32'h30, BASE_ADDR + 32'h2, ALT_BASE_ADDR + 32'h3c, 32'h04000200};
    void'($urandom(32'hff0a));
    for (int pass = 0; pass < 2; pass++) begin
      rst <= 1'b1;
      debugModeStrapN <= (pass == 0);
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 12; i++) shadow[i] = expReset(i, pass == 1);
      readAll(BASE_ADDR);
      checkPins();
      // All-output codes on ports A and D show the reserved code on D pins 4 and 6.
      for (int k = 0; k < 26; k++) begin
        idx = (k < 2) ? 3 * k : $urandom_range(11);
        v = (k < 2) ? 32'h5555 : $urandom;
        s = (k < 2) ? 4'hf : 4'($urandom);
        apb(1'b1, ((k % 2) ? ALT_BASE_ADDR : BASE_ADDR) + 32'(4 * idx), v, s);
        check({95'h0, err}, 96'h0);
        if (s[0]) shadow[idx][7:0] = v[7:0];
        if (s[1]) shadow[idx][15:8] = v[15:8];
        checkPins();
      end
      readAll(ALT_BASE_ADDR);
      // The strap only matters while rst is held, so moving it now must change nothing.
      debugModeStrapN <= ~debugModeStrapN;
      repeat (10) @(posedge clock);
      for (int b = 0; b < 4; b++) begin
        apb(1'b1, bad[b], 32'hffff, 4'hf);
        check({95'h0, err}, 96'h1);
        apb(1'b0, bad[b], 32'h0, 4'h0);
        check({95'h0, err}, 96'h1);
        check(rd, 96'h0);
      end
      readAll(BASE_ADDR);
      checkPins();
    end
    print_verdict();
  end
endmodule // pin_function_select_bank_tb
